// ---- rtl/servw_regs.vh ----
`ifndef SERVW_REGS_VH
`define SERVW_REGS_VH

// Encoding fields of the view registers (coproc 15, opc1 0)
`define SERVW_CP_NUM          4'hF
`define SERVW_OPC1            3'h0
`define SERVW_CRN             4'h5
`define SERVW_CRM_GRP4        4'h4
`define SERVW_CRM_GRP5        4'h5
`define SERVW_OP2_FEAT_HI     3'h4
`define SERVW_OP2_STAT_LO     3'h2
`define SERVW_OP2_AUXA_LO     3'h0
`define SERVW_OP2_AUXA_HI     3'h1
`define SERVW_OP2_AUXB_LO     3'h4
`define SERVW_OP2_AUXB_HI     3'h5

// Exception levels
`define SERVW_EL0             2'h0
`define SERVW_EL1             2'h1
`define SERVW_EL2             2'h2
`define SERVW_EL3             2'h3

// Result codes of an access
`define SERVW_RES_OK          3'h0
`define SERVW_RES_UNDEF       3'h1
`define SERVW_RES_TRAP_EL2    3'h2
`define SERVW_RES_TRAP_HYP    3'h3
`define SERVW_RES_TRAP_EL3    3'h4
`define SERVW_RES_TRAP_MON    3'h5

// Out-of-range policy choices
`define SERVW_OOR_UNKNOWN     2'h0
`define SERVW_OOR_RAZWI       2'h1
`define SERVW_OOR_NOP         2'h2
`define SERVW_OOR_UNDEF       2'h3

// Word halves of 64-bit record fields
`define SERVW_LO_MSB          31
`define SERVW_HI_LSB          32
`define SERVW_HI_MSB          63

// Zero words
`define SERVW_ZERO32          32'h00000000

`endif

// ---- rtl/servw_view.v ----
// How it works
// - Every view acts on the record named by the record select index.
// - The feature high view reads bits 63:32 of the record feature, c5,c4,4.
// - Aux A low view reads and writes bits 31:0 of aux A, at c5,c5,0.
// - Aux A high view reads and writes bits 63:32 of aux A, at c5,c5,1.
// - Aux B low view reads and writes bits 31:0 of aux B, at c5,c5,4.
// - Aux B high view reads and writes bits 63:32 of aux B, at c5,c5,5.
// - Status low view reads and writes bits 31:0 of status, at c5,c4,2.
// - Any view access from level 0 is undefined.
// - A zero count or index at or above it takes one permitted outcome.
// - 64-bit hypervisor trap bit set traps non-secure level 1 to level 2.
// - 32-bit hypervisor trap bit set gives a hyp trap for non-secure EL1.
// - 64-bit monitor trap bit set traps levels 1 and 2 to level 3.
// - 32-bit monitor trap bit set traps every mode above level 0 but monitor mode.
// - Traps resolve in the usual exception priority order.
// - One copy of each view serves both security states.
// - Without the error extension every view access is undefined.
`timescale 1ns/100ps
`default_nettype none
`include "servw_regs.vh"

module servw_view #(
    parameter       SEL_W     = 4,
    parameter [1:0] OOR_MODE  = `SERVW_OOR_RAZWI,
    parameter       EXT_IMPL  = 1
) (
    input  wire              clk_sys,
    input  wire              rst,
    // Coprocessor move request from the core
    input  wire              acc_valid,
    input  wire              acc_write,
    input  wire [3:0]        acc_cp,
    input  wire [2:0]        acc_opc1,
    input  wire [3:0]        acc_crn,
    input  wire [3:0]        acc_crm,
    input  wire [2:0]        acc_opc2,
    input  wire [31:0]       acc_wdata,
    // Core state
    input  wire [1:0]        cur_el,
    input  wire              cur_nonsecure,
    input  wire              cur_monitor_mode,
    input  wire              el2_impl,
    input  wire              el2_is64,
    input  wire              el3_impl,
    input  wire              el3_is64,
    input  wire              hyp64_error_trap_bit,
    input  wire              hyp32_error_trap_bit,
    input  wire              monitor64_error_trap_bit,
    input  wire              monitor32_error_trap_bit,
    input  wire [SEL_W-1:0]  record_select_index,
    input  wire [SEL_W:0]    implemented_record_count,
    // Selected record read data from record storage
    input  wire [63:0]       record_feature_reg,
    input  wire [63:0]       record_aux_a_reg,
    input  wire [63:0]       record_aux_b_reg,
    input  wire [31:0]       record_status_lo,
    // Record index and write strobes toward record storage
    output wire [SEL_W-1:0]  rec_index,
    output reg               rec_aux_a_lo_we_q,
    output reg               rec_aux_a_hi_we_q,
    output reg               rec_aux_b_lo_we_q,
    output reg               rec_aux_b_hi_we_q,
    output reg               rec_status_we_q,
    output reg  [31:0]       rec_wdata_q,
    // Answer to the core
    output reg               resp_valid_q,
    output reg  [2:0]        resp_code_q,
    output reg  [31:0]       resp_rdata_q
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------

    // Common encoding prefix
    wire base_hit = (acc_cp == `SERVW_CP_NUM) &&
                    (acc_opc1 == `SERVW_OPC1) &&
                    (acc_crn == `SERVW_CRN);
    wire g4 = base_hit && (acc_crm == `SERVW_CRM_GRP4);
    wire g5 = base_hit && (acc_crm == `SERVW_CRM_GRP5);

    wire hit_feat = g4 && (acc_opc2 == `SERVW_OP2_FEAT_HI);
    wire hit_stat = g4 && (acc_opc2 == `SERVW_OP2_STAT_LO);
    wire hit_aalo = g5 && (acc_opc2 == `SERVW_OP2_AUXA_LO);
    wire hit_aahi = g5 && (acc_opc2 == `SERVW_OP2_AUXA_HI);
    wire hit_ablo = g5 && (acc_opc2 == `SERVW_OP2_AUXB_LO);
    wire hit_abhi = g5 && (acc_opc2 == `SERVW_OP2_AUXB_HI);
    wire hit_any  = hit_feat | hit_stat | hit_aalo | hit_aahi |
                    hit_ablo | hit_abhi;

    // Writes to the feature view are not a legal encoding
    wire bad_write = hit_feat && acc_write;

    // Index straight from the select field, one copy for both states
    assign rec_index = record_select_index;

    // Out-of-range selection
    wire oor = (implemented_record_count == {(SEL_W+1){1'b0}}) ||
               ({1'b0, record_select_index} >=
                implemented_record_count);

    // ------------------------------------------------------------
    // Permission and trap resolution
    // ------------------------------------------------------------

    // Priority: undefined first, then EL2 traps, then EL3 traps, then out-of-range undefined
    reg [2:0] code_d;
    always @* begin
        code_d = `SERVW_RES_OK;
        if (EXT_IMPL == 0 || bad_write) begin
            code_d = `SERVW_RES_UNDEF;
        end else if (cur_el == `SERVW_EL0) begin
            code_d = `SERVW_RES_UNDEF;
        end else if (el2_impl && el2_is64 && hyp64_error_trap_bit &&
                     cur_nonsecure && cur_el == `SERVW_EL1) begin
            code_d = `SERVW_RES_TRAP_EL2;
        end else if (el2_impl && !el2_is64 && hyp32_error_trap_bit &&
                     cur_nonsecure && cur_el == `SERVW_EL1) begin
            code_d = `SERVW_RES_TRAP_HYP;
        end else if (el3_impl && el3_is64 && monitor64_error_trap_bit &&
                     (cur_el == `SERVW_EL1 ||
                      cur_el == `SERVW_EL2)) begin
            code_d = `SERVW_RES_TRAP_EL3;
        end else if (el3_impl && !el3_is64 &&
                     monitor32_error_trap_bit &&
                     !cur_monitor_mode) begin
            code_d = `SERVW_RES_TRAP_MON;
        end else if (oor && OOR_MODE == `SERVW_OOR_UNDEF) begin
            code_d = `SERVW_RES_UNDEF;
        end
    end

    // Access really touches the record
    wire perform = acc_valid && hit_any && (code_d == `SERVW_RES_OK);
    wire oor_mute = oor && (OOR_MODE == `SERVW_OOR_RAZWI ||
                            OOR_MODE == `SERVW_OOR_NOP);
    wire do_wr = perform && acc_write && !oor_mute;

    // Read mux of the selected record
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = `SERVW_ZERO32;
        if (hit_feat) begin
            rdata_d = record_feature_reg[`SERVW_HI_MSB:`SERVW_HI_LSB];
        end else if (hit_stat) begin
            rdata_d = record_status_lo;
        end else if (hit_aalo) begin
            rdata_d = record_aux_a_reg[`SERVW_LO_MSB:0];
        end else if (hit_aahi) begin
            rdata_d = record_aux_a_reg[`SERVW_HI_MSB:`SERVW_HI_LSB];
        end else if (hit_ablo) begin
            rdata_d = record_aux_b_reg[`SERVW_LO_MSB:0];
        end else if (hit_abhi) begin
            rdata_d = record_aux_b_reg[`SERVW_HI_MSB:`SERVW_HI_LSB];
        end
        if (oor_mute || acc_write) begin
            rdata_d = `SERVW_ZERO32;
        end
    end

    // ------------------------------------------------------------
    // Registered answer and write strobes
    // ------------------------------------------------------------

    // Unknown encodings are answered as undefined
    always @(posedge clk_sys) begin
        if (rst) begin
            resp_valid_q      <= 1'b0;
            resp_code_q       <= `SERVW_RES_OK;
            resp_rdata_q      <= `SERVW_ZERO32;
            rec_aux_a_lo_we_q <= 1'b0;
            rec_aux_a_hi_we_q <= 1'b0;
            rec_aux_b_lo_we_q <= 1'b0;
            rec_aux_b_hi_we_q <= 1'b0;
            rec_status_we_q   <= 1'b0;
            rec_wdata_q       <= `SERVW_ZERO32;
        end else begin
            resp_valid_q      <= acc_valid;
            resp_code_q       <= hit_any ? code_d : `SERVW_RES_UNDEF;
            resp_rdata_q      <= perform ? rdata_d : `SERVW_ZERO32;
            rec_aux_a_lo_we_q <= do_wr && hit_aalo;
            rec_aux_a_hi_we_q <= do_wr && hit_aahi;
            rec_aux_b_lo_we_q <= do_wr && hit_ablo;
            rec_aux_b_hi_we_q <= do_wr && hit_abhi;
            rec_status_we_q   <= do_wr && hit_stat;
            if (do_wr) begin
                rec_wdata_q <= acc_wdata;
            end
        end
    end

endmodule // servw_view

`default_nettype wire

// ---- sim/servw_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module servw_chk #(parameter SEL_W = 4) (
    input wire logic             clk_sys, rst, acc_valid, acc_write,
    input wire logic [3:0]       acc_crm,
    input wire logic [2:0]       acc_opc2, resp_code_q,
    input wire logic [1:0]       cur_el,
    input wire logic [31:0]      acc_wdata, rec_wdata_q, resp_rdata_q,
    input wire logic [SEL_W-1:0] record_select_index, rec_index,
    input wire logic             rec_aux_a_hi_we_q, rec_status_we_q,
    input wire logic             resp_valid_q
);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
// Request and answer steps
sequence s_take; acc_valid; endsequence
property p_answer; s_take |=> resp_valid_q; endproperty
property p_only; resp_valid_q |-> $past(acc_valid); endproperty
property p_index; rec_index == record_select_index; endproperty
property p_low; s_take ##0 (cur_el == 2'h0) |=> resp_code_q == 3'h1;
endproperty
property p_fault_rd; resp_valid_q && resp_code_q != 3'h0
    |-> resp_rdata_q == 32'h0; endproperty
property p_fault_we; resp_code_q != 3'h0
    |-> !rec_status_we_q && !rec_aux_a_hi_we_q; endproperty
property p_stat_we; rec_status_we_q |-> rec_wdata_q == $past(acc_wdata)
    && $past(acc_write && acc_crm == 4'h4 && acc_opc2 == 3'h2); endproperty
property p_auxa_hi; rec_aux_a_hi_we_q
    |-> $past(acc_crm == 4'h5 && acc_opc2 == 3'h1); endproperty
a_answer: assert property (p_answer)
    else $error("No answer after request");
a_only: assert property (p_only)
    else $error("Answer without request");
a_index: assert property (p_index)
    else $error("Record index differs from select");
a_low: assert property (p_low)
    else $error("Level 0 access not undefined");
a_fault_rd: assert property (p_fault_rd)
    else $error("Read data on fault");
a_fault_we: assert property (p_fault_we)
    else $error("Strobe on fault");
a_stat_we: assert property (p_stat_we)
    else $error("Bad status strobe");
a_auxa_hi: assert property (p_auxa_hi)
    else $error("Bad aux high strobe");
endmodule // servw_chk
bind servw_view servw_chk #(.SEL_W(SEL_W)) chk_u (.*);
`default_nettype wire

// ---- sim/servw_store.sv ----
`timescale 1ns/100ps
`default_nettype none
module servw_store #(parameter SEL_W = 4) (
    input wire logic             clk_sys, rec_status_we_q,
    input wire logic             rec_aux_a_lo_we_q, rec_aux_a_hi_we_q,
    input wire logic             rec_aux_b_lo_we_q, rec_aux_b_hi_we_q,
    input wire logic [SEL_W-1:0] rec_index,
    input wire logic [31:0]      rec_wdata_q,
    output logic     [63:0]      record_feature_reg, record_aux_a_reg,
    output logic     [63:0]      record_aux_b_reg,
    output logic     [31:0]      record_status_lo
);
logic [63:0] fr [2**SEL_W], aa [2**SEL_W], ab [2**SEL_W];
logic [31:0] st [2**SEL_W];
// Feature words carry the record number
initial for (int i = 0; i < 2**SEL_W; i++) begin
    fr[i] = {28'hFEA0000, 4'(i), 32'h0};
    aa[i] = 64'h0;
    ab[i] = 64'h0;
    st[i] = 32'h0;
end
assign record_feature_reg = fr[rec_index];
assign record_aux_a_reg   = aa[rec_index];
assign record_aux_b_reg   = ab[rec_index];
assign record_status_lo   = st[rec_index];
// Half-word writes from the strobes
always @(posedge clk_sys) begin
    if (rec_aux_a_lo_we_q) aa[rec_index][31:0] <= rec_wdata_q;
    if (rec_aux_a_hi_we_q) aa[rec_index][63:32] <= rec_wdata_q;
    if (rec_aux_b_lo_we_q) ab[rec_index][31:0] <= rec_wdata_q;
    if (rec_aux_b_hi_we_q) ab[rec_index][63:32] <= rec_wdata_q;
    if (rec_status_we_q) st[rec_index] <= rec_wdata_q;
end
endmodule // servw_store
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic clk_sys = 1'b0, rst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
logic [3:0] acc_cp = 4'hF, acc_crn = 4'h5, acc_crm = 4'h0;
logic [2:0] acc_opc1 = 3'h0, acc_opc2 = 3'h0;
logic [31:0] acc_wdata = 32'h0;
logic [1:0] cur_el = 2'h1;
logic cur_nonsecure = 1'b1, cur_monitor_mode = 1'b0, el2_impl = 1'b1;
logic el2_is64 = 1'b1, el3_impl = 1'b1, el3_is64 = 1'b1;
logic hyp64_error_trap_bit = 1'b0, hyp32_error_trap_bit = 1'b0;
logic monitor64_error_trap_bit = 1'b0, monitor32_error_trap_bit = 1'b0;
logic [3:0] record_select_index = 4'h1;
logic [4:0] implemented_record_count = 5'h04;
wire logic [63:0] record_feature_reg, record_aux_a_reg, record_aux_b_reg;
wire logic [31:0] record_status_lo, rec_wdata_q, resp_rdata_q;
wire logic [3:0] rec_index;
wire logic rec_aux_a_lo_we_q, rec_aux_a_hi_we_q, rec_aux_b_lo_we_q;
wire logic rec_aux_b_hi_we_q, rec_status_we_q, resp_valid_q;
wire logic [2:0] resp_code_q;
int mismatches = 0, samples_checked = 0, cycles = 0;
logic [3:0] vm [5] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h4};
logic [2:0] vo [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2};
servw_view #(.SEL_W(4)) dut_u (.*);
servw_store #(.SEL_W(4)) store_u (.*);
always #5 clk_sys = ~clk_sys;
// Cut a hang short
always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
        mismatches++;
        print_verdict();
    end
end
task automatic print_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
// One access, answer judged one cycle later
task automatic acc(input logic w, input logic [3:0] m, input logic [2:0] o,
    input logic [31:0] d, input logic [2:0] ec, input logic [31:0] er);
    acc_valid = 1'b1;
    acc_write = w;
    acc_crm = m;
    acc_opc2 = o;
    acc_wdata = d;
    @(negedge clk_sys);
    acc_valid = 1'b0;
    samples_checked++;
    if (!(resp_valid_q === 1'b1 && resp_code_q === ec && resp_rdata_q === er))
    begin
        mismatches++;
        $display("Error at %0t: bad answer", $time);
    end
    @(negedge clk_sys);
endtask
task automatic t_views;
    for (int i = 0; i < 5; i++) acc(1'b1, vm[i], vo[i], 32'hC0DE0000 + 32'(i),
        3'h0, 32'h0);
    for (int i = 0; i < 5; i++) acc(1'b0, vm[i], vo[i], 32'h0,
        3'h0, 32'hC0DE0000 + 32'(i));
    acc(1'b0, 4'h4, 3'h4, 32'h0, 3'h0, 32'hFEA00001);
    record_select_index = 4'h2;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'h0);
endtask
task automatic t_faults;
    cur_el = 2'h0;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h1, 32'h0);
    cur_el = 2'h1;
    acc(1'b1, 4'h4, 3'h4, 32'h1, 3'h1, 32'h0);
    record_select_index = 4'h5;
    acc(1'b1, 4'h5, 3'h0, 32'hFFFF, 3'h0, 32'h0);
    implemented_record_count = 5'h00;
    record_select_index = 4'h1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'h0);
    implemented_record_count = 5'h08;
    record_select_index = 4'h5;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'h0);
    implemented_record_count = 5'h04;
    record_select_index = 4'h1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'hC0DE0000);
endtask
task automatic t_traps;
    hyp64_error_trap_bit = 1'b1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h2, 32'h0);
    cur_nonsecure = 1'b0;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'hC0DE0000);
    cur_nonsecure = 1'b1;
    el2_is64 = 1'b0;
    hyp32_error_trap_bit = 1'b1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h3, 32'h0);
    cur_el = 2'h0;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h1, 32'h0);
    cur_el = 2'h2;
    monitor64_error_trap_bit = 1'b1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h4, 32'h0);
    el3_is64 = 1'b0;
    monitor32_error_trap_bit = 1'b1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h5, 32'h0);
    cur_el = 2'h3;
    cur_monitor_mode = 1'b1;
    acc(1'b0, 4'h5, 3'h0, 32'h0, 3'h0, 32'hC0DE0000);
endtask
initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_views();
    t_faults();
    t_traps();
    print_verdict();
end
endmodule // testbench
`default_nettype wire
